//--- hw/cpusc_regs.svh
`ifndef CPUSC_REGS_SVH
`define CPUSC_REGS_SVH
// Register byte offsets
`define CPUSC_STATUS_OFS 8'h00
`define CPUSC_CORE_OFS 8'h04
`define CPUSC_TRAP_OFS 8'h08
// Status flag field positions
`define CPUSC_ST_SA 13
`define CPUSC_ST_SAB 10
`define CPUSC_ST_DC 8
`define CPUSC_ST_IPL_HI 7
`define CPUSC_ST_IPL_LO 5
`define CPUSC_ST_N 3
`define CPUSC_ST_OV 2
`define CPUSC_ST_Z 1
`define CPUSC_ST_C 0
`define CPUSC_ST_SB 12
// Core control field positions
`define CPUSC_CO_EDT 11
`define CPUSC_CO_CPU_PRIORITY_MSB 3
`define CPUSC_CO_US 12
`define CPUSC_CO_ACC_A_CLIP_ENABLE 7
`define CPUSC_CO_ACC_B_CLIP_ENABLE 6
`define CPUSC_CO_STORE_CLIP_ENABLE 5
`define CPUSC_CO_SUPER_CLIP_MODE 4
`define CPUSC_CO_PSV 2
`define CPUSC_CO_RND 1
`define CPUSC_CO_IF 0
// Trap control field position
`define CPUSC_TR_NESTING_DISABLE 15
// Reset values and masks
`define CPUSC_CORE_RESET 16'h0020
`define CPUSC_CORE_WMASK 16'h10f7
`define CPUSC_DEPTH_MAX 3'h7
`define CPUSC_IPL_MASKED 3'h7
`endif

//--- hw/cpusc_pkg.sv
package cpusc_pkg;
    // ALU operation codes
    typedef enum logic [2:0] {
        ALU_ADD = 3'b000,
        ALU_SUB = 3'b001,
        ALU_ADDC = 3'b010,
        ALU_SUBB = 3'b011,
        ALU_AND = 3'b100,
        ALU_IOR = 3'b101,
        ALU_XOR = 3'b110
    } cpusc_aluop_type;
    // Bus slave data phase states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_RDWAIT = 2'b10,
        BUS_RDDONE = 2'b11
    } cpusc_bus_type;
endpackage : cpusc_pkg

//--- hw/cpusc_alu_if.sv
`timescale 1ns/10ps
interface cpusc_alu_if;
    import cpusc_pkg::*;
    cpusc_aluop_type op;
    logic byteMode;
    logic [15:0] opA;
    logic [15:0] opB;
    logic carryIn;
    logic [15:0] result;
    logic carryOut;
    logic nibbleCarry;
    logic overflow;
    logic negative;
    logic zero;
    logic arith;
    modport core (output op, byteMode, opA, opB, carryIn,
        input result, carryOut, nibbleCarry, overflow, negative, zero, arith);
    modport unit (input op, byteMode, opA, opB, carryIn,
        output result, carryOut, nibbleCarry, overflow, negative, zero, arith);
endinterface : cpusc_alu_if

//--- hw/cpusc_alu.sv
`timescale 1ns/10ps
module cpusc_alu
    import cpusc_pkg::*;
(
    cpusc_alu_if.unit alu
);
    logic [15:0] bIn;
    logic cin;
    logic [16:0] sumW;
    logic [8:0] sumB;
    logic [4:0] sumN;
    logic [15:0] res;
    logic msbA;
    logic msbB;
    logic msbR;

    ////////////////////////////////////////////////////////////////////////
    // 16-bit or byte-mode 8-bit two's complement
    // Subtraction adds the complement, so carry out means no borrow
    always_comb
    begin
        bIn = (alu.op == ALU_SUB || alu.op == ALU_SUBB) ? ~alu.opB : alu.opB;
        unique case (alu.op)
            ALU_SUB: cin = 1'b1;
            ALU_ADDC, ALU_SUBB: cin = alu.carryIn;
            default: cin = 1'b0;
        endcase
        sumW = {1'b0, alu.opA} + {1'b0, bIn} + {16'h0000, cin};
        sumB = {1'b0, alu.opA[7:0]} + {1'b0, bIn[7:0]} + {8'h00, cin};
        sumN = {1'b0, alu.opA[3:0]} + {1'b0, bIn[3:0]} + {4'h0, cin};
        unique case (alu.op)
            ALU_AND: res = alu.opA & alu.opB;
            ALU_IOR: res = alu.opA | alu.opB;
            ALU_XOR: res = alu.opA ^ alu.opB;
            default: res = sumW[15:0];
        endcase
        // Byte results keep the upper byte clear
        if (alu.byteMode)
            res = {8'h00, res[7:0]};
        msbA = alu.byteMode ? alu.opA[7] : alu.opA[15];
        msbB = alu.byteMode ? bIn[7] : bIn[15];
        msbR = alu.byteMode ? res[7] : res[15];
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag outputs of the operation
    assign alu.result = res;
    assign alu.arith = !(alu.op inside {ALU_AND, ALU_IOR, ALU_XOR});
    assign alu.carryOut = alu.byteMode ? sumB[8] : sumW[16];
    assign alu.nibbleCarry = alu.byteMode ? sumN[4] : sumB[8];
    assign alu.overflow = (msbA == msbB) && (msbR != msbA);
    assign alu.negative = msbR;
    assign alu.zero = (res == 16'h0000);
endmodule : cpusc_alu

//--- hw/cpusc_status_core.sv
`timescale 1ns/10ps
`include "cpusc_regs.svh"
module cpusc_status_core
    import cpusc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic aluStart,
    input wire cpusc_aluop_type aluOp,
    input wire logic aluByteMode,
    input wire logic [15:0] aluOperandA,
    input wire logic [15:0] aluOperandB,
    output logic [15:0] aluResult,
    input wire logic dspUpdateA,
    input wire logic dspGuardA,
    input wire logic dspSaturateA,
    input wire logic dspUpdateB,
    input wire logic dspGuardB,
    input wire logic dspSaturateB,
    input wire logic doLoopStart,
    input wire logic doLoopEnd,
    input wire logic repeatLoopBusy,
    input wire logic priorityLoad,
    input wire logic [3:0] priorityValue,
    output logic doLoopEarlyExit,
    output logic [3:0] cpuPriorityLevel,
    output logic userIntDisable,
    output logic unsignedMultiplySel,
    output logic accAClipEnable,
    output logic accBClipEnable,
    output logic storeClipEnable,
    output logic superClipMode,
    output logic programWindowEnable,
    output logic roundingSelect,
    output logic integerMultiplySel
);
    cpusc_alu_if aluBus();
    cpusc_bus_type busState, next_busState;
    logic [7:0] addrQ, next_addrQ;
    logic [31:0] next_hrdata;
    logic accept, wrStatus, wrCore, wrTrap;
    logic [15:0] wd;
    // Status flags
    logic accAGuard, accBGuard, accAClip, accBClip;
    logic nibbleCarry, signedWrap, negFlag, zeroFlag, carryFlag;
    logic [2:0] priorityLow;
    logic next_accAGuard, next_accBGuard, next_accAClip, next_accBClip;
    logic next_nibbleCarry, next_signedWrap, next_negFlag;
    logic next_zeroFlag, next_carryFlag;
    logic [2:0] next_priorityLow;
    // Core control and trap control state
    logic [15:0] coreCfg, next_coreCfg;
    logic priorityMsb, next_priorityMsb;
    logic [2:0] doDepth, next_doDepth;
    logic next_doLoopEarlyExit;
    logic nestingDisable, next_nestingDisable;
    logic [15:0] next_aluResult;
    logic [15:0] statusView, coreView;

    cpusc_alu aluUnit (
        .alu (aluBus.unit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Operands to the ALU; carry in comes from the stored carry flag
    assign aluBus.op = aluOp;
    assign aluBus.byteMode = aluByteMode;
    assign aluBus.opA = aluOperandA;
    assign aluBus.opB = aluOperandB;
    assign aluBus.carryIn = carryFlag;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: writes take no wait state, reads one so hrdata is a flop
    assign accept = hsel && htrans[1] && hready;
    assign wd = hwdata[15:0];
    assign wrStatus = (busState == BUS_WRITE) && (addrQ == `CPUSC_STATUS_OFS);
    assign wrCore = (busState == BUS_WRITE) && (addrQ == `CPUSC_CORE_OFS);
    assign wrTrap = (busState == BUS_WRITE) && (addrQ == `CPUSC_TRAP_OFS);
    assign hreadyout = (busState != BUS_RDWAIT);
    assign hresp = 1'b0;

    // Readback views of both registers
    always_comb
    begin
        statusView = {accAGuard, accBGuard, accAClip, accBClip,
            accAGuard | accBGuard, accAClip | accBClip, doDepth != 3'h0,
            nibbleCarry, priorityLow, repeatLoopBusy, negFlag, signedWrap,
            zeroFlag, carryFlag};
        coreView = {3'b000, coreCfg[`CPUSC_CO_US], 1'b0, doDepth,
            coreCfg[7:4], priorityMsb, coreCfg[2:0]};
    end

    // Next bus state and read data
    always_comb
    begin
        next_busState = BUS_IDLE;
        next_addrQ = addrQ;
        next_hrdata = hrdata;
        if (busState == BUS_RDWAIT)
        begin
            next_busState = BUS_RDDONE;
            // Unmapped addresses read zero
            unique case (addrQ)
                `CPUSC_STATUS_OFS: next_hrdata = {16'h0000, statusView};
                `CPUSC_CORE_OFS: next_hrdata = {16'h0000, coreView};
                `CPUSC_TRAP_OFS: next_hrdata = {16'h0000, nestingDisable,
                    15'h0000};
                default: next_hrdata = 32'h00000000;
            endcase
        end
        else if (accept)
        begin
            next_busState = hwrite ? BUS_WRITE : BUS_RDWAIT;
            next_addrQ = haddr[7:0];
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busState <= BUS_IDLE;
            addrQ <= 8'h00;
            hrdata <= 32'h00000000;
        end
        else
        begin
            busState <= next_busState;
            addrQ <= next_addrQ;
            hrdata <= next_hrdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags: software write first, hardware events override it,
    // so an event in the cycle of a clear is never lost
    always_comb
    begin
        next_accAGuard = accAGuard;
        next_accBGuard = accBGuard;
        next_accAClip = accAClip;
        next_accBClip = accBClip;
        next_nibbleCarry = nibbleCarry;
        next_signedWrap = signedWrap;
        next_negFlag = negFlag;
        next_zeroFlag = zeroFlag;
        next_carryFlag = carryFlag;
        next_priorityLow = priorityLow;
        next_aluResult = aluResult;
        if (wrStatus)
        begin
            next_accAClip = accAClip && wd[`CPUSC_ST_SA] && wd[`CPUSC_ST_SAB];
            next_accBClip = accBClip && wd[`CPUSC_ST_SB] && wd[`CPUSC_ST_SAB];
            next_nibbleCarry = wd[`CPUSC_ST_DC];
            next_negFlag = wd[`CPUSC_ST_N];
            next_signedWrap = wd[`CPUSC_ST_OV];
            next_zeroFlag = wd[`CPUSC_ST_Z];
            next_carryFlag = wd[`CPUSC_ST_C];
            if (!nestingDisable)
                next_priorityLow = wd[`CPUSC_ST_IPL_HI:`CPUSC_ST_IPL_LO];
        end
        if (aluStart)
        begin
            next_aluResult = aluBus.result;
            next_negFlag = aluBus.negative;
            if (aluOp == ALU_ADDC || aluOp == ALU_SUBB)
                next_zeroFlag = zeroFlag && aluBus.zero;
            else
                next_zeroFlag = aluBus.zero;
            // Logic operations leave the carry family untouched
            if (aluBus.arith)
            begin
                next_carryFlag = aluBus.carryOut;
                next_nibbleCarry = aluBus.nibbleCarry;
                next_signedWrap = aluBus.overflow;
            end
        end
        if (dspUpdateA)
        begin
            next_accAGuard = dspGuardA;
            next_accAClip = next_accAClip || dspSaturateA;
        end
        if (dspUpdateB)
        begin
            next_accBGuard = dspGuardB;
            next_accBClip = next_accBClip || dspSaturateB;
        end
        if (priorityLoad)
            next_priorityLow = priorityValue[2:0];
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            accAGuard <= 1'b0;
            accBGuard <= 1'b0;
            accAClip <= 1'b0;
            accBClip <= 1'b0;
            nibbleCarry <= 1'b0;
            signedWrap <= 1'b0;
            negFlag <= 1'b0;
            zeroFlag <= 1'b0;
            carryFlag <= 1'b0;
            priorityLow <= 3'h0;
            aluResult <= 16'h0000;
        end
        else
        begin
            accAGuard <= next_accAGuard;
            accBGuard <= next_accBGuard;
            accAClip <= next_accAClip;
            accBClip <= next_accBClip;
            nibbleCarry <= next_nibbleCarry;
            signedWrap <= next_signedWrap;
            negFlag <= next_negFlag;
            zeroFlag <= next_zeroFlag;
            carryFlag <= next_carryFlag;
            priorityLow <= next_priorityLow;
            aluResult <= next_aluResult;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core control, nesting depth, early exit and trap control
    always_comb
    begin
        next_coreCfg = coreCfg;
        next_priorityMsb = priorityMsb;
        next_doDepth = doDepth;
        next_doLoopEarlyExit = doLoopEarlyExit;
        next_nestingDisable = nestingDisable;
        if (wrTrap)
            next_nestingDisable = wd[`CPUSC_TR_NESTING_DISABLE];
        if (wrCore)
        begin
            next_coreCfg = wd & `CPUSC_CORE_WMASK;
            next_priorityMsb = priorityMsb && wd[`CPUSC_CO_CPU_PRIORITY_MSB];
            if (wd[`CPUSC_CO_EDT] && doDepth != 3'h0)
                next_doLoopEarlyExit = 1'b1;
        end
        if (priorityLoad)
            next_priorityMsb = priorityValue[3];
        if (doLoopStart && !doLoopEnd && doDepth != `CPUSC_DEPTH_MAX)
            next_doDepth = doDepth + 3'h1;
        else if (doLoopEnd && !doLoopStart && doDepth != 3'h0)
            next_doDepth = doDepth - 3'h1;
        // The request ends with the iteration that closes the loop
        if (doLoopEnd)
            next_doLoopEarlyExit = 1'b0;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            coreCfg <= `CPUSC_CORE_RESET;
            priorityMsb <= 1'b0;
            doDepth <= 3'h0;
            doLoopEarlyExit <= 1'b0;
            nestingDisable <= 1'b0;
        end
        else
        begin
            coreCfg <= next_coreCfg;
            priorityMsb <= next_priorityMsb;
            doDepth <= next_doDepth;
            doLoopEarlyExit <= next_doLoopEarlyExit;
            nestingDisable <= next_nestingDisable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode outputs to the DSP engine and the interrupt logic
    // priority and masking
    assign cpuPriorityLevel = {priorityMsb, priorityLow};
    assign userIntDisable = priorityMsb || priorityLow == `CPUSC_IPL_MASKED;
    assign unsignedMultiplySel = coreCfg[`CPUSC_CO_US];
    assign accAClipEnable = coreCfg[`CPUSC_CO_ACC_A_CLIP_ENABLE];
    assign accBClipEnable = coreCfg[`CPUSC_CO_ACC_B_CLIP_ENABLE];
    assign storeClipEnable = coreCfg[`CPUSC_CO_STORE_CLIP_ENABLE];
    assign superClipMode = coreCfg[`CPUSC_CO_SUPER_CLIP_MODE];
    assign programWindowEnable = coreCfg[`CPUSC_CO_PSV];
    assign roundingSelect = coreCfg[`CPUSC_CO_RND];
    assign integerMultiplySel = coreCfg[`CPUSC_CO_IF];

    ////////////////////////////////////////////////////////////////////////
    // Checks on the flag and control behaviour
    default clocking cbk @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence seqEdtWrite;
        wrCore && wd[`CPUSC_CO_EDT] && doDepth != 3'h0 && !doLoopEnd;
    endsequence
    sequence seqLoopClose;
        !doLoopEnd [*1] ##1 doLoopEnd;
    endsequence

    AST_GUARD_FOLLOWS: assert property (
        dspUpdateA |=> accAGuard == $past(dspGuardA))
        else $error("guard overflow flag A wrong");
    AST_CLIP_HOLDS: assert property (
        accAClip && !wrStatus |=> accAClip)
        else $error("clip sticky flag A dropped");
    AST_NO_SOFT_SET: assert property (
        wrStatus && !accBClip && !dspUpdateB |=> !accBClip)
        else $error("software set clip sticky B");
    AST_OR_VIEW: assert property (
        statusView[11] == (accAGuard || accBGuard) &&
        statusView[10] == (accAClip || accBClip))
        else $error("combined status bits wrong");
    AST_BOTH_CLEAR: assert property (
        wrStatus && !wd[`CPUSC_ST_SAB] && !dspUpdateA && !dspUpdateB
        |=> !accAClip && !accBClip)
        else $error("combined clear missed a flag");
    AST_LOOP_SHOWN: assert property (
        doLoopStart && !doLoopEnd |=> statusView[9])
        else $error("DO loop not shown active");
    AST_IPL_LOCK: assert property (
        wrStatus && nestingDisable && !priorityLoad
        |=> $stable(priorityLow))
        else $error("priority changed while locked");
    AST_MASKING: assert property (
        priorityLoad && priorityValue[3] |=> userIntDisable [*1]
        ##0 cpuPriorityLevel[3])
        else $error("user interrupts not masked");
    AST_ZERO_STICKY: assert property (
        aluStart && aluOp == ALU_ADDC && !aluBus.zero |=> !zeroFlag)
        else $error("zero flag not cleared");
    AST_EARLY_EXIT: assert property (
        seqEdtWrite |=> doLoopEarlyExit until_with doLoopEnd)
        else $error("early exit request not held");
    AST_EXIT_ENDS: assert property (
        doLoopEarlyExit ##0 seqLoopClose |=> !doLoopEarlyExit)
        else $error("early exit outlived the loop");
    AST_DEPTH_UP: assert property (
        doLoopStart && !doLoopEnd && doDepth < 3'h7
        |=> doDepth == $past(doDepth) + 3'h1)
        else $error("nesting depth not raised");
endmodule : cpusc_status_core

//--- test/cpusc_exec_model.sv
`timescale 1ns/10ps
// Execution and DSP side: strobes one event at a time, like the core does
module cpusc_exec_model
    import cpusc_pkg::*;
(
    input wire logic clk,
    output cpusc_aluop_type aluOp,
    output logic aluStart,
    output logic aluByteMode,
    output logic [15:0] opA,
    output logic [15:0] opB,
    output logic [5:0] dsp,
    output logic [2:0] loopEv,
    output logic [4:0] prio
);
    // Quiet lines at time zero
    initial
    begin
        aluOp = ALU_ADD;
        {aluStart, aluByteMode, opA, opB} = 34'h0;
        {dsp, loopEv, prio} = 14'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // byte or word op
    task automatic alu(input cpusc_aluop_type op, input logic bm,
        input logic [15:0] a, input logic [15:0] b);
        @(posedge clk);
        aluStart <= 1'b1;
        aluOp <= op;
        aluByteMode <= bm;
        opA <= a;
        opB <= b;
        @(posedge clk);
        aluStart <= 1'b0;
        // Stale operands are scrambled so nothing leans on them
        opA <= ~a;
        opB <= ~b;
        @(negedge clk);
    endtask : alu

    // One-cycle event pulse; loopEv[0] is the repeat level and stays
    task automatic ev(input logic [5:0] d, input logic [2:0] l,
        input logic [4:0] p);
        @(posedge clk);
        dsp <= d;
        loopEv <= l;
        prio <= p;
        @(posedge clk);
        dsp <= 6'h00;
        loopEv[2:1] <= 2'h0;
        prio <= 5'h00;
        @(negedge clk);
    endtask : ev
endmodule : cpusc_exec_model

//--- test/testbench.sv
`timescale 1ns/10ps
`include "cpusc_regs.svh"
`define CHK(g, e) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("ERROR %0t: got %h want %h", $time, g, e); \
        end \
    end
module testbench;
    import cpusc_pkg::*;
    localparam logic [7:0] ST = `CPUSC_STATUS_OFS;
    localparam logic [7:0] CO = `CPUSC_CORE_OFS;
    localparam logic [7:0] TR = `CPUSC_TRAP_OFS;
    logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, aluStart, aluByteMode, earlyExit, userIntDisable;
    cpusc_aluop_type aluOp;
    logic [15:0] opA, opB, aluResult;
    logic [5:0] dsp;
    logic [2:0] loopEv;
    logic [4:0] prio;
    logic [3:0] cpuPriorityLevel;
    logic [7:0] modes;
    int bad_count = 0;
    int n_checks = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    cpusc_exec_model cpusc_exec_model_i (.clk(clk), .aluOp(aluOp),
        .aluStart(aluStart), .aluByteMode(aluByteMode), .opA(opA),
        .opB(opB), .dsp(dsp), .loopEv(loopEv), .prio(prio));

    cpusc_status_core cpusc_status_core_i (.clk(clk), .resetn(resetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .aluStart(aluStart), .aluOp(aluOp), .aluByteMode(aluByteMode),
        .aluOperandA(opA), .aluOperandB(opB), .aluResult(aluResult),
        .dspUpdateA(dsp[5]), .dspGuardA(dsp[4]), .dspSaturateA(dsp[3]),
        .dspUpdateB(dsp[2]), .dspGuardB(dsp[1]), .dspSaturateB(dsp[0]),
        .doLoopStart(loopEv[2]), .doLoopEnd(loopEv[1]),
        .repeatLoopBusy(loopEv[0]), .priorityLoad(prio[4]),
        .priorityValue(prio[3:0]), .doLoopEarlyExit(earlyExit),
        .cpuPriorityLevel(cpuPriorityLevel),
        .userIntDisable(userIntDisable),
        .unsignedMultiplySel(modes[7]), .accAClipEnable(modes[6]),
        .accBClipEnable(modes[5]), .storeClipEnable(modes[4]),
        .superClipMode(modes[3]), .programWindowEnable(modes[2]),
        .roundingSelect(modes[1]), .integerMultiplySel(modes[0]));

    ////////////////////////////////////////////////////////////////////////
    // One AHB word transfer; a read is compared with d
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        if (!w)
            `CHK(hrdata, {16'h0, d})
        // Let the write land before anyone looks at the outputs
        @(negedge clk);
    endtask : bus

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // Whole run is a few hundred cycles; this is ample
    initial
    begin
        #2000000;
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        bus(0, ST, 16'h0000);
        bus(0, CO, 16'h0020);
        bus(0, 8'h0c, 16'h0000);
        `CHK(hresp, 1'b0)
        `CHK(modes, 8'h10)
        bus(1, CO, 16'hffff);
        bus(0, CO, 16'h10f7);
        `CHK(modes, 8'hff)
        `CHK(cpuPriorityLevel, 4'h0)
        bus(1, CO, 16'h0000);
        `CHK(modes, 8'h00)
        $display("test core done");
        cpusc_exec_model_i.alu(ALU_ADD, 1'b0, 16'h7fff, 16'h0001);
        `CHK(aluResult, 16'h8000)
        bus(0, ST, 16'h010c);
        cpusc_exec_model_i.alu(ALU_SUB, 1'b0, 16'h0005, 16'h0005);
        bus(0, ST, 16'h0103);
        cpusc_exec_model_i.alu(ALU_ADD, 1'b1, 16'h000f, 16'h0001);
        bus(0, ST, 16'h0100);
        cpusc_exec_model_i.alu(ALU_ADD, 1'b1, 16'h00ff, 16'h0001);
        `CHK(aluResult, 16'h0000)
        bus(0, ST, 16'h0103);
        cpusc_exec_model_i.alu(ALU_AND, 1'b0, 16'h8000, 16'hffff);
        bus(0, ST, 16'h0109);
        cpusc_exec_model_i.alu(ALU_XOR, 1'b0, 16'h00ff, 16'h00ff);
        bus(0, ST, 16'h0103);
        cpusc_exec_model_i.alu(ALU_ADDC, 1'b0, 16'h0001, 16'h0001);
        `CHK(aluResult, 16'h0003)
        bus(0, ST, 16'h0000);
        cpusc_exec_model_i.alu(ALU_SUBB, 1'b0, 16'h0003, 16'h0002);
        bus(0, ST, 16'h0101);
        cpusc_exec_model_i.alu(ALU_IOR, 1'b1, 16'h1280, 16'h0001);
        `CHK(aluResult, 16'h0081)
        bus(0, ST, 16'h0109);
        bus(1, ST, 16'h0000);
        $display("test alu done");
        cpusc_exec_model_i.ev(6'b111000, 3'h0, 5'h00);
        bus(0, ST, 16'hac00);
        cpusc_exec_model_i.ev(6'b100000, 3'h0, 5'h00);
        bus(0, ST, 16'h2400);
        cpusc_exec_model_i.ev(6'b000111, 3'h0, 5'h00);
        bus(0, ST, 16'h7c00);
        bus(1, ST, 16'hffff);
        bus(0, ST, 16'h7def);
        `CHK({cpuPriorityLevel, userIntDisable}, 5'h0f)
        bus(1, ST, 16'h3000);
        bus(0, ST, 16'h4800);
        cpusc_exec_model_i.ev(6'b000100, 3'h0, 5'h00);
        bus(0, ST, 16'h0000);
        $display("test dsp done");
        bus(1, TR, 16'h8000);
        bus(0, TR, 16'h8000);
        bus(1, ST, 16'h00e0);
        bus(0, ST, 16'h0000);
        bus(1, TR, 16'h0000);
        bus(1, ST, 16'h00a0);
        bus(0, ST, 16'h00a0);
        `CHK(userIntDisable, 1'b0)
        bus(1, CO, 16'h0008);
        bus(0, CO, 16'h0000);
        cpusc_exec_model_i.ev(6'h00, 3'h0, 5'h18);
        bus(0, CO, 16'h0008);
        `CHK({cpuPriorityLevel, userIntDisable}, 5'h11)
        bus(1, CO, 16'h0000);
        bus(0, CO, 16'h0000);
        $display("test priority done");
        repeat (8) cpusc_exec_model_i.ev(6'h00, 3'b100, 5'h00);
        bus(0, CO, 16'h0700);
        cpusc_exec_model_i.ev(6'h00, 3'b001, 5'h00);
        bus(0, ST, 16'h0210);
        bus(1, CO, 16'h0800);
        `CHK(earlyExit, 1'b1)
        bus(0, CO, 16'h0700);
        cpusc_exec_model_i.ev(6'h00, 3'b010, 5'h00);
        `CHK(earlyExit, 1'b0)
        bus(0, CO, 16'h0600);
        repeat (7) cpusc_exec_model_i.ev(6'h00, 3'b010, 5'h00);
        bus(0, ST, 16'h0000);
        $display("test loops done");
        conclude();
    end
endmodule : testbench
